// >>> dv/rts_radio_src.sv
// radio receiver model: drives the demodulated time-code pulse line
// assumes callers sit on a falling clock edge and use it one call at a time
`timescale 1ns/1ns
module rts_radio_src #(
   parameter integer ms_cyc = 5
) (
   input wire core_clk,
   output logic pulse_in
);
   initial pulse_in = 1'b0;
   // low is the idle level; a long low stands for the missing minute mark
   task send(input integer high_ms, input integer low_ms);
      pulse_in = 1'b1;
      repeat (high_ms * ms_cyc) @(negedge core_clk);
      pulse_in = 1'b0;
      repeat (low_ms * ms_cyc) @(negedge core_clk);
   endtask
endmodule // rts_radio_src

// >>> dv/rts_top_properties.sv
// checker for the radio time slave top: position, error flag, register port
// assumes it is bound to rts_top and sees only that module's ports
`timescale 1ns/1ns
module rts_top_properties #(
   parameter [31:0] reg_base_addr = 32'h0000_0000,
   parameter [31:0] reg_top_addr = 32'h0000_FFFF
) (
   input wire core_clk,
   input wire rst,
   input wire [7:0] core_state_info,
   input wire core_state_valid,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_rvalid,
   input wire [1:0] s_axi_rresp,
   input wire [31:0] s_axi_rdata,
   input wire offset_adj_valid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire [5:0] pos = core_state_info[5:0];
   wire err = core_state_info[6];
   wire rd_out = s_axi_araddr < reg_base_addr || s_axi_araddr > reg_top_addr;
   wire rd_pos = s_axi_araddr == reg_base_addr + 32'h0000_0030;
   ////////////////////////////////////////////////////////////
   sequence s_rd_taken; s_axi_arvalid && !s_axi_arready && !s_axi_rvalid; endsequence
   sequence s_wr_taken; s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid; endsequence
   sequence s_wr_answer; s_axi_awready && s_axi_wready ##1 s_axi_bvalid; endsequence
   property p_state_valid; !$past(rst) |-> core_state_valid; endproperty
   a_state_valid: assert property (p_state_valid) else $error("status valid low");
   property p_wrap; $changed(pos) && $past(pos) == 6'h3B |-> pos == 6'h00; endproperty
   a_wrap: assert property (p_wrap) else $error("position did not wrap to zero");
   property p_step; $changed(pos) |-> pos == $past(pos) + 6'h01 || pos == 6'h00 || pos == 6'h3B; endproperty
   a_step: assert property (p_step) else $error("position skipped");
   // the flag may land up to two cycles after the jump because status is registered
   property p_err_jump; $changed(pos) && pos == 6'h3B && $past(pos) != 6'h3A |-> ##[0:2] err; endproperty
   a_err_jump: assert property (p_err_jump) else $error("bad jump not flagged");
   property p_sticky; $fell(err) |-> $past(s_axi_wready) || $past(s_axi_wready, 2) || $past(s_axi_wready, 3); endproperty
   a_sticky: assert property (p_sticky) else $error("error flag dropped by itself");
   property p_wr_answer; s_wr_taken |=> s_wr_answer; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_rd_out; s_rd_taken ##0 rd_out |-> ##2 s_axi_rvalid && s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_rd_out: assert property (p_rd_out) else $error("out of range read answered");
   property p_pos_read; s_rd_taken ##0 rd_pos |-> ##2 s_axi_rvalid && s_axi_rdata < 32'h0000_003C; endproperty
   a_pos_read: assert property (p_pos_read) else $error("position read out of field");
   property p_adj_pulse; offset_adj_valid |=> !offset_adj_valid; endproperty
   a_adj_pulse: assert property (p_adj_pulse) else $error("adjust valid held");
endmodule // rts_top_properties

bind rts_top rts_top_properties #(.reg_base_addr(reg_base_addr), .reg_top_addr(reg_top_addr)) u_props (
   .core_clk(core_clk), .rst(rst), .core_state_info(core_state_info), .core_state_valid(core_state_valid),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .offset_adj_valid(offset_adj_valid));

// >>> dv/tb_top.sv
// bench for rts_top in register port mode and in fixed setup mode, fed by a radio pulse model
// assumes the hw files, the checker and the pulse model are compiled first
`timescale 1ns/1ns
module tb_top;
   // a huge period makes one millisecond five clocks, so a minute fits the run
   localparam integer ms_cyc = 5;
   typedef struct {bit wr; logic [31:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} rts_row_t;
   rts_row_t rows [14] = '{
      '{0, 32'h0000_0000, 32'h0, 32'h0000_0000, 2'h0}, '{0, 32'h0000_0004, 32'h0, 32'h0000_0000, 2'h0},
      '{0, 32'h0000_0030, 32'h0, 32'h0000_0000, 2'h0}, '{0, 32'h0000_0020, 32'h0, 32'h0000_0000, 2'h0},
      '{1, 32'h0000_0020, 32'hFFFF_FFFF, 32'h0, 2'h0}, '{0, 32'h0000_0020, 32'h0, 32'h3FFF_FFFF, 2'h0},
      '{1, 32'h0000_0030, 32'h0000_003F, 32'h0, 2'h0}, '{0, 32'h0000_0030, 32'h0, 32'h0000_0000, 2'h0},
      '{0, 32'h0001_0000, 32'h0, 32'h0000_0000, 2'h3}, '{1, 32'h0001_0000, 32'h0000_0001, 32'h0, 2'h3},
      '{0, 32'h0000_0000, 32'h0, 32'h0000_0000, 2'h0}, '{0, 32'h0000_0008, 32'h0, 32'h0000_0000, 2'h0},
      '{1, 32'h0000_0000, 32'h0000_0001, 32'h0, 2'h0}, '{0, 32'h0000_0000, 32'h0, 32'h0000_0001, 2'h0}};
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] fx = 32'h0000_0000;
   logic [31:0] clock_time_sec = 32'h0000_0000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic adj_seen = 1'b0;
   logic fixed_run = 1'b1;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pulse_in;
   wire core_state_valid, offset_adj_valid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, offset_adj_interval, offset_adj_sec, offset_adj_ns;
   wire [7:0] core_state_info, fixed_state_info;
   wire [3:0] hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};
   int num_errors = 0;
   int num_checks = 0;
   ////////////////////////////////////////////////////////////
   rts_top #(.sys_period_ns(200000), .pulse_filter_on(1)) u_rts_top (
      .core_clk, .rst, .fixed_corr_sec(fx), .fixed_corr_ns(fx), .fixed_corr_frac(fx[1:0]), .fixed_corr_sign(fx[31]),
      .fixed_corr_step(fx[2]), .fixed_radio_path_delay(fx[15:0]), .fixed_setup_valid(fx[3]), .core_state_info,
      .core_state_valid, .clock_time_sec, .clock_time_ns(clock_time_sec), .clock_time_valid(1'b1),
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .s_axi_rdata, .pulse_in,
      .offset_adj_sec, .offset_adj_ns, .offset_adj_frac(), .offset_adj_sign(), .offset_adj_step(),
      .offset_adj_interval, .offset_adj_valid);
   rts_radio_src #(.ms_cyc(ms_cyc)) u_rts_radio_src (.core_clk, .pulse_in);
   // second copy in fixed setup mode, sharing the pulse line and the write channel
   rts_top #(.use_fixed_setup(1), .sys_period_ns(200000)) u_rts_top_fixed (
      .core_clk, .rst, .fixed_corr_sec(fx), .fixed_corr_ns(fx), .fixed_corr_frac(2'h0), .fixed_corr_sign(1'b0),
      .fixed_corr_step(1'b0), .fixed_radio_path_delay(fx[15:0]), .fixed_setup_valid(fixed_run),
      .core_state_info(fixed_state_info), .core_state_valid(), .clock_time_sec, .clock_time_ns(clock_time_sec),
      .clock_time_valid(1'b1), .s_axi_awvalid, .s_axi_awready(), .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
      .s_axi_wready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid(), .s_axi_bready, .s_axi_bresp(),
      .s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid(),
      .s_axi_rready(1'b0), .s_axi_rresp(), .s_axi_rdata(), .pulse_in, .offset_adj_sec(), .offset_adj_ns(),
      .offset_adj_frac(), .offset_adj_sign(), .offset_adj_step(), .offset_adj_interval(), .offset_adj_valid());
   always #5 core_clk = ~core_clk;
   always @(negedge core_clk) clock_time_sec <= clock_time_sec + 32'h0000_0001;
   always @(posedge core_clk) if (offset_adj_valid === 1'b1) adj_seen <= 1'b1;
   ////////////////////////////////////////////////////////////
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task report_and_stop();
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task wait_hi(input int k);
      int n;
      n = 0;
      while (hs[k] !== 1'b1) begin
         if (n++ == 20) begin
            num_errors++;
            $display("unexpected handshake %0d: expected 1, seen 0", k);
            report_and_stop();
         end
         @(negedge core_clk);
      end
   endtask
   task axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      s_axi_awaddr = a;
      s_axi_wdata = d;
      s_axi_wstrb = s;
      s_axi_awvalid = 1'b1;
      s_axi_wvalid = 1'b1;
      wait_hi(0);
      @(negedge core_clk);
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b1;
      wait_hi(1);
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
      @(negedge core_clk);
      s_axi_bready = 1'b0;
   endtask
   task axi_read(input logic [31:0] a, input logic [31:0] x, input logic [1:0] r);
      s_axi_araddr = a;
      s_axi_arvalid = 1'b1;
      wait_hi(2);
      @(negedge core_clk);
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b1;
      wait_hi(3);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
      check("rdata", s_axi_rdata, x);
      @(negedge core_clk);
      s_axi_rready = 1'b0;
   endtask
   task check_pos(input logic [5:0] p);
      axi_read(32'h0000_0030, {26'h0, p}, 2'h0);
      check("position", {26'h0, core_state_info[5:0]}, {26'h0, p});
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      check("state valid", {31'h0, core_state_valid}, 32'h0000_0001);
      check("state info", {24'h0, core_state_info}, 32'h0000_0000);
      foreach (rows[i]) begin
         if (rows[i].wr) axi_write(rows[i].a, rows[i].d, 4'hF, rows[i].r);
         else axi_read(rows[i].a, rows[i].x, rows[i].r);
      end
      u_rts_radio_src.send(70, 20);
      u_rts_radio_src.send(70, 20);
      check_pos(6'h02);
      u_rts_radio_src.send(50, 20);
      check_pos(6'h02);
      u_rts_radio_src.send(70, 1600);
      check_pos(6'h3B);
      axi_read(32'h0000_0004, 32'h0000_0001, 2'h0);
      axi_write(32'h0000_0020, 32'h0000_0064, 4'hF, 2'h0);
      axi_write(32'h0000_0010, 32'h0000_0005, 4'hF, 2'h0);
      u_rts_radio_src.send(70, 20);
      check_pos(6'h00);
      axi_read(32'h0000_0004, 32'h0000_0001, 2'h0);
      axi_write(32'h0000_0004, 32'h0000_0001, 4'h1, 2'h0);
      axi_read(32'h0000_0004, 32'h0000_0000, 2'h0);
      check("adjust seen", {31'h0, adj_seen}, 32'h0000_0001);
      check("interval", offset_adj_interval, 32'h3B9A_CA00);
      // stamp seconds and ns carry the same count, so only delay 100 and correction 5 remain
      check("offset", offset_adj_sec - offset_adj_ns, 32'h0000_0069);
      fx = 32'h1234_5678;
      repeat (57) u_rts_radio_src.send(70, 20);
      check_pos(6'h39);
      u_rts_radio_src.send(70, 1600);
      check_pos(6'h3B);
      axi_read(32'h0000_0004, 32'h0000_0000, 2'h0);
      axi_write(32'h0000_0000, 32'h0000_0000, 4'hF, 2'h0);
      check_pos(6'h00);
      check("fixed state", {24'h0, fixed_state_info}, 32'h0000_00BB);
      fixed_run = 1'b0;
      repeat (2) @(negedge core_clk);
      check("fixed idle", {24'h0, fixed_state_info}, 32'h0000_0000);
      report_and_stop();
   end
endmodule // tb_top

// >>> hw/rts_map.vh
// register offsets, field positions, reset values and timing figures
// assumes includers sit in the same folder; definitions only
`ifndef RTS_MAP_VH
`define RTS_MAP_VH
`define RTS_OFS_CTRL 16'h0000
`define RTS_OFS_STATUS 16'h0004
`define RTS_OFS_VERSION 16'h000C
`define RTS_OFS_CORR 16'h0010
`define RTS_OFS_AIR 16'h0020
`define RTS_OFS_POS 16'h0030
`define RTS_CTRL_EN_BIT 0
`define RTS_STAT_ERR_BIT 0
`define RTS_COR_SIGN_BIT 31
`define RTS_AIR_W 30
`define RTS_POS_W 6
`define RTS_RST_WORD 32'h0000_0000
`define RTS_RST_POS 6'h00
`define RTS_LAST_POS 6'h3B
`define RTS_PRE_LAST_POS 6'h3A
`define RTS_RANGE_SPAN 32'h0000_FFFF
`define RTS_RESP_OKAY 2'h0
`define RTS_RESP_DECERR 2'h3
`define RTS_NS_PER_SEC 32'h3B9A_CA00
`define RTS_NS_PER_MS 32'h000F_4240
`define RTS_SIM_MS_CYC 32'h0000_0064
`define RTS_MS_W 12
`define RTS_MIN_PULSE_MS 12'h003C
`define RTS_ONE_MS 12'h0096
`define RTS_GAP_MS 12'h05DC
`define RTS_MS_MAX 12'hFFF
`endif

// >>> hw/rts_pulse_meas.v
// measures radio pulse widths and gaps in milliseconds
// assumes pulse_in is synchronous to clk and ms_tick is a one-cycle enable
`timescale 1ns/1ns
`include "rts_map.vh"
module rts_pulse_meas #(
   parameter pulse_filter_on = 1
) (
   input wire clk,
   input wire rst,
   input wire ms_tick,
   input wire run,
   input wire pulse_in,
   output reg rise_evt,
   output reg sym_end,
   output reg sym_one,
   output reg gap_evt
);
   localparam [`RTS_MS_W-1:0] MIN_MS = pulse_filter_on ? `RTS_MIN_PULSE_MS : 12'h000;
   reg in_d_reg;
   reg [`RTS_MS_W-1:0] hi_ms_reg;
   reg [`RTS_MS_W-1:0] lo_ms_reg;
   reg gap_done_reg;
   wire rise = pulse_in & ~in_d_reg;
   wire fall = ~pulse_in & in_d_reg;
   wire keep = hi_ms_reg >= MIN_MS;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         in_d_reg <= 1'b0;
         hi_ms_reg <= 12'h000;
         lo_ms_reg <= 12'h000;
         gap_done_reg <= 1'b0;
         rise_evt <= 1'b0;
         sym_end <= 1'b0;
         sym_one <= 1'b0;
         gap_evt <= 1'b0;
      end else if (!run) begin
         in_d_reg <= pulse_in;
         hi_ms_reg <= 12'h000;
         lo_ms_reg <= 12'h000;
         gap_done_reg <= 1'b0;
         rise_evt <= 1'b0;
         sym_end <= 1'b0;
         gap_evt <= 1'b0;
      end else begin
         in_d_reg <= pulse_in;
         rise_evt <= rise;
         sym_end <= fall & keep;
         gap_evt <= 1'b0;
         if (fall & keep) begin
            sym_one <= hi_ms_reg >= `RTS_ONE_MS;
            lo_ms_reg <= 12'h000;
            gap_done_reg <= 1'b0;
         end
         if (rise)
            hi_ms_reg <= 12'h000;
         else if (pulse_in & ms_tick & (hi_ms_reg != `RTS_MS_MAX))
            hi_ms_reg <= hi_ms_reg + 12'h001;
         // short glitches are dropped, so the gap count runs across them
         if (~pulse_in & ms_tick & ~(fall & keep)) begin
            if (lo_ms_reg != `RTS_MS_MAX)
               lo_ms_reg <= lo_ms_reg + 12'h001;
            if ((lo_ms_reg >= `RTS_GAP_MS) & ~gap_done_reg) begin
               gap_evt <= 1'b1;
               gap_done_reg <= 1'b1;
            end
         end
      end
   end
endmodule // rts_pulse_meas

// >>> hw/rts_time_add.v
// adds or subtracts a seconds/nanoseconds amount to a positive time
// assumes both nanosecond inputs are below one second
`timescale 1ns/1ns
`include "rts_map.vh"
module rts_time_add (
   input wire [31:0] a_sec,
   input wire [31:0] a_ns,
   input wire [31:0] b_sec,
   input wire [31:0] b_ns,
   input wire b_neg,
   output reg [31:0] sum_sec,
   output reg [31:0] sum_ns
);
   reg [32:0] ns_wide;
   always @* begin
      ns_wide = 33'h0_0000_0000;
      sum_sec = a_sec;
      sum_ns = a_ns;
      if (!b_neg) begin
         ns_wide = {1'b0, a_ns} + {1'b0, b_ns};
         if (ns_wide >= {1'b0, `RTS_NS_PER_SEC}) begin
            sum_ns = ns_wide[31:0] - `RTS_NS_PER_SEC;
            sum_sec = a_sec + b_sec + 32'h0000_0001;
         end else begin
            sum_ns = ns_wide[31:0];
            sum_sec = a_sec + b_sec;
         end
      end else if (a_ns >= b_ns) begin
         sum_ns = a_ns - b_ns;
         sum_sec = a_sec - b_sec;
      end else begin
         // borrow one second; result stays below one second
         sum_ns = a_ns + `RTS_NS_PER_SEC - b_ns;
         sum_sec = a_sec - b_sec - 32'h0000_0001;
      end
   end
endmodule // rts_time_add

// >>> hw/rts_top.v
// radio time-code slave top: symbol tracking, register port, time records
// assumes synchronous inputs on core_clk and an AXI4-Lite master
// Notes on behaviour
// - symbol position reads as six low bits, values zero to fifty-nine
// - after position fifty-nine the next symbol is position zero
// - jumping to fifty-nine from anything but fifty-eight is an error
// - a build option picks fixed setup inputs or the register port
// - clock period in ns is a build option, default 20, used for timing
// - with the filter on, pulses under 60 ms are not symbols
// - the register port decodes only between base and top address; outside it answers DECERR
// - time is seconds, nanoseconds, fraction, sign and step marker
// - adjustment carries a time and a 32-bit interval
// - adjustment holds a valid bit; act on it only when set
// - a configured correction is added to the decoded time
// - a status record goes out with its own valid bit
// - pin path delay in ns is a build option and is compensated
// - a build option selects simulation or synthesis behaviour
// - behaviour options are fixed at build time
`timescale 1ns/1ns
`include "rts_map.vh"
module rts_top #(
   parameter use_fixed_setup = 0,
   parameter integer sys_period_ns = 20,
   parameter integer pin_path_delay_ns = 0,
   parameter pulse_filter_on = 1,
   parameter [31:0] reg_base_addr = 32'h0000_0000,
   parameter [31:0] reg_top_addr = 32'h0000_FFFF,
   parameter sim_mode = 0,
   parameter [31:0] version_word = 32'h0001_0000,
   parameter [31:0] adjust_interval_ns = 32'h3B9A_CA00
) (
   input wire core_clk,
   input wire rst,
   input wire [31:0] fixed_corr_sec,
   input wire [31:0] fixed_corr_ns,
   input wire [1:0] fixed_corr_frac,
   input wire fixed_corr_sign,
   input wire fixed_corr_step,
   input wire [15:0] fixed_radio_path_delay,
   input wire fixed_setup_valid,
   output reg [7:0] core_state_info,
   output reg core_state_valid,
   input wire [31:0] clock_time_sec,
   input wire [31:0] clock_time_ns,
   input wire clock_time_valid,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   output reg [1:0] s_axi_bresp,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   input wire [31:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [1:0] s_axi_rresp,
   output reg [31:0] s_axi_rdata,
   input wire pulse_in,
   output reg [31:0] offset_adj_sec,
   output reg [31:0] offset_adj_ns,
   output reg [1:0] offset_adj_frac,
   output reg offset_adj_sign,
   output reg offset_adj_step,
   output reg [31:0] offset_adj_interval,
   output reg offset_adj_valid
);
   ////////////////////////////////////////////////////////////////////////////////
   // build-time figures; nothing here can change at run time
   localparam [31:0] MS_CYC = sim_mode ? `RTS_SIM_MS_CYC : (`RTS_NS_PER_MS / sys_period_ns);
   localparam [31:0] PIN_DLY = pin_path_delay_ns;

   function in_range;
      input [31:0] addr;
      begin
         in_range = (addr >= reg_base_addr) && (addr <= reg_top_addr);
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i])
               merge[i*8 +: 8] = data[i*8 +: 8];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // millisecond enable
   reg [31:0] div_reg;
   reg ms_tick_reg;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_reg <= 32'h0000_0000;
         ms_tick_reg <= 1'b0;
      end else if (div_reg >= MS_CYC - 32'h0000_0001) begin
         div_reg <= 32'h0000_0000;
         ms_tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 32'h0000_0001;
         ms_tick_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // configuration registers and run selection
   reg ctrl_en_reg;
   reg corr_sign_reg;
   reg [30:0] corr_sec_reg;
   reg [`RTS_AIR_W-1:0] air_reg;
   reg err_reg;
   reg [`RTS_POS_W-1:0] pos_reg;

   wire run = use_fixed_setup ? fixed_setup_valid : ctrl_en_reg;
   wire [31:0] air_ns = use_fixed_setup ? {16'h0000, fixed_radio_path_delay} : {2'b00, air_reg};
   wire [31:0] corr_sec = use_fixed_setup ? fixed_corr_sec : {1'b0, corr_sec_reg};
   wire [31:0] corr_ns = use_fixed_setup ? fixed_corr_ns : 32'h0000_0000;
   wire corr_neg = use_fixed_setup ? fixed_corr_sign : corr_sign_reg;
   wire [31:0] total_dly = PIN_DLY + air_ns;

   ////////////////////////////////////////////////////////////////////////////////
   // register port: one write and one read in flight at a time
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
   wire rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
   wire wr_hit = in_range(s_axi_awaddr);
   wire rd_hit = in_range(s_axi_araddr);
   wire [31:0] wr_rel = s_axi_awaddr - reg_base_addr;
   wire [31:0] rd_rel = s_axi_araddr - reg_base_addr;
   wire [15:0] wr_ofs = wr_rel[15:0];
   wire [15:0] rd_ofs = rd_rel[15:0];
   wire wr_ok = wr_go & wr_hit;
   // fixed setup owns the configuration, so port writes to it are dropped
   wire cfg_wr = wr_ok & ~use_fixed_setup;
   wire [31:0] ctrl_word = {31'h0000_0000, ctrl_en_reg};
   wire [31:0] corr_word = {corr_sign_reg, corr_sec_reg};
   wire [31:0] air_word = {2'b00, air_reg};
   wire [31:0] ctrl_wr = merge(ctrl_word, s_axi_wdata, s_axi_wstrb);
   wire [31:0] corr_wr = merge(corr_word, s_axi_wdata, s_axi_wstrb);
   wire [31:0] air_wr = merge(air_word, s_axi_wdata, s_axi_wstrb);

   reg [31:0] rd_word;
   always @* begin
      rd_word = `RTS_RST_WORD;
      case (rd_ofs)
         `RTS_OFS_CTRL: rd_word = ctrl_word;
         `RTS_OFS_STATUS: rd_word = {31'h0000_0000, err_reg};
         `RTS_OFS_VERSION: rd_word = version_word;
         `RTS_OFS_CORR: rd_word = corr_word;
         `RTS_OFS_AIR: rd_word = air_word;
         `RTS_OFS_POS: rd_word = {26'h000_0000, pos_reg};
         default: rd_word = `RTS_RST_WORD;
      endcase
      if (!rd_hit)
         rd_word = `RTS_RST_WORD;
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RTS_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RTS_RESP_OKAY;
         s_axi_rdata <= `RTS_RST_WORD;
         ctrl_en_reg <= 1'b0;
         corr_sign_reg <= 1'b0;
         corr_sec_reg <= 31'h0000_0000;
         air_reg <= 30'h0000_0000;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_go)
            s_axi_bresp <= wr_hit ? `RTS_RESP_OKAY : `RTS_RESP_DECERR;
         s_axi_arready <= rd_go;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (rd_go) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `RTS_RESP_OKAY : `RTS_RESP_DECERR;
         end
         if (cfg_wr & (wr_ofs == `RTS_OFS_CTRL))
            ctrl_en_reg <= ctrl_wr[`RTS_CTRL_EN_BIT];
         if (cfg_wr & (wr_ofs == `RTS_OFS_CORR)) begin
            corr_sign_reg <= corr_wr[`RTS_COR_SIGN_BIT];
            corr_sec_reg <= corr_wr[30:0];
         end
         if (cfg_wr & (wr_ofs == `RTS_OFS_AIR))
            air_reg <= air_wr[`RTS_AIR_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pulse measurement and symbol position
   wire rise_evt;
   wire sym_end;
   wire sym_one;
   wire gap_evt;
   rts_pulse_meas #(
      .pulse_filter_on(pulse_filter_on)
   ) u_meas (
      .clk(core_clk),
      .rst(rst),
      .ms_tick(ms_tick_reg),
      .run(run),
      .pulse_in(pulse_in),
      .rise_evt(rise_evt),
      .sym_end(sym_end),
      .sym_one(),
      .gap_evt(gap_evt)
   );

   // the missing minute-mark pulse shows as a long gap: that is position 59
   wire seq_err = run & gap_evt & (pos_reg != `RTS_PRE_LAST_POS);
   wire err_clr = wr_ok & (wr_ofs == `RTS_OFS_STATUS) & s_axi_wstrb[0] & s_axi_wdata[`RTS_STAT_ERR_BIT];

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pos_reg <= `RTS_RST_POS;
         err_reg <= 1'b0;
      end else begin
         if (!run)
            pos_reg <= `RTS_RST_POS;
         else if (gap_evt)
            pos_reg <= `RTS_LAST_POS;
         else if (sym_end) begin
            if (pos_reg == `RTS_LAST_POS)
               pos_reg <= `RTS_RST_POS;
            else
               pos_reg <= pos_reg + 6'h01;
         end
         // a new error in the clearing cycle keeps the flag set
         if (seq_err)
            err_reg <= 1'b1;
         else if (err_clr)
            err_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // minute stamp: delay compensated, then corrected
   reg [31:0] stamp_sec_reg;
   reg [31:0] stamp_ns_reg;
   reg stamp_ok_reg;
   wire [31:0] comp_sec;
   wire [31:0] comp_ns;
   wire [31:0] fin_sec;
   wire [31:0] fin_ns;
   rts_time_add u_comp (
      .a_sec(stamp_sec_reg),
      .a_ns(stamp_ns_reg),
      .b_sec(32'h0000_0000),
      .b_ns(total_dly),
      .b_neg(1'b1),
      .sum_sec(comp_sec),
      .sum_ns(comp_ns)
   );
   rts_time_add u_corr (
      .a_sec(comp_sec),
      .a_ns(comp_ns),
      .b_sec(corr_sec),
      .b_ns(corr_ns),
      .b_neg(corr_neg),
      .sum_sec(fin_sec),
      .sum_ns(fin_ns)
   );

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stamp_sec_reg <= 32'h0000_0000;
         stamp_ns_reg <= 32'h0000_0000;
         stamp_ok_reg <= 1'b0;
         offset_adj_sec <= 32'h0000_0000;
         offset_adj_ns <= 32'h0000_0000;
         offset_adj_frac <= 2'h0;
         offset_adj_sign <= 1'b0;
         offset_adj_step <= 1'b0;
         offset_adj_interval <= 32'h0000_0000;
         offset_adj_valid <= 1'b0;
         core_state_info <= 8'h00;
         core_state_valid <= 1'b0;
      end else begin
         // the edge opening symbol zero is taken at position 59
         if (rise_evt & (pos_reg == `RTS_LAST_POS)) begin
            stamp_sec_reg <= clock_time_sec;
            stamp_ns_reg <= clock_time_ns;
            stamp_ok_reg <= clock_time_valid;
         end
         // valid only once the opening symbol is complete and a stamp exists
         offset_adj_valid <= sym_end & (pos_reg == `RTS_LAST_POS) & stamp_ok_reg & run;
         if (sym_end & (pos_reg == `RTS_LAST_POS)) begin
            offset_adj_sec <= fin_sec;
            offset_adj_ns <= fin_ns;
            offset_adj_frac <= 2'h0;
            offset_adj_sign <= 1'b0;
            offset_adj_step <= 1'b0;
            offset_adj_interval <= adjust_interval_ns;
         end
         core_state_info <= {run, err_reg, pos_reg};
         core_state_valid <= 1'b1;
      end
   end
endmodule // rts_top
